// ---- rtl/irc_pkg.sv ----
// Purpose: Constants for the interrupt and reset steering block
// Assumes: One 100 MHz bus clock, AXI4-Lite register access
// Notes:   Register offsets are byte addresses of aligned words
package irc_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_PIN_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_TOP_PRIO  = 8'h04;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [1:0] RESP_OKAY      = 2'b00;
    localparam logic [1:0] RESP_SLVERR    = 2'b10;
    // ==========================================================
    // Field positions and reset values
    localparam int         EDGE_SEL_BIT   = 7;
    localparam int         CONNECT_BIT    = 6;
    localparam int         DELAY_BIT      = 5;
    localparam logic [7:0] PIN_CTRL_RST   = 8'h60;
    localparam logic [7:0] TOP_PRIO_RST   = 8'hF2;
    localparam logic [7:0] LOW_BYTE_MAX   = 8'hF2;
    localparam int         ST_CAUSE_LSB   = 0;
    localparam int         ST_EDGE_BIT    = 2;
    localparam int         ST_STOP_BIT    = 3;
    localparam int         ST_PEND_LSB    = 8;
    localparam logic [1:0] CAUSE_NORMAL   = 2'h0;
    localparam logic [1:0] CAUSE_CLKMON   = 2'h1;
    localparam logic [1:0] CAUSE_WDOG     = 2'h2;
    // ==========================================================
    // Vectors
    localparam logic [15:0] VEC_RESET     = 16'hFFFE;
    localparam logic [15:0] VEC_CLKMON    = 16'hFFFC;
    localparam logic [15:0] VEC_WDOG      = 16'hFFFA;
    localparam logic [15:0] VEC_UNIMPL    = 16'hFFF8;
    localparam logic [15:0] VEC_SWTRAP    = 16'hFFF6;
    localparam logic [15:0] VEC_NMI       = 16'hFFF4;
    localparam logic [7:0]  VEC_HIGH      = 8'hFF;
    localparam int          NUM_MASKABLE  = 16;
    // Default order, index 0 highest; index 0 is the external pin
    localparam logic [7:0] MASK_LOW [0:NUM_MASKABLE-1] = '{
        8'hF2, 8'hF0, 8'hEE, 8'hEC, 8'hEA, 8'hE8, 8'hE6, 8'hE4,
        8'hE2, 8'hE0, 8'hDE, 8'hDC, 8'hDA, 8'hD8, 8'hD6, 8'hD2};
    // ==========================================================
    // Timing, in bus clocks at 100 MHz
    localparam int CLK_PERIOD_NS      = 10;
    localparam int RST_DRIVE_CLOCKS   = 16;
    localparam int RST_SAMPLE_CLOCKS  = 8;
    localparam int STOP_DELAY_CLOCKS  = 4096;
    localparam int EXT_RESET_MIN      = 32;
    localparam logic [4:0]  RST_DRIVE_LAST  = 5'(RST_DRIVE_CLOCKS - 1);
    localparam logic [4:0]  RST_SAMPLE_LAST = 5'(RST_SAMPLE_CLOCKS - 1);
    localparam logic [12:0] STOP_DELAY_LAST = 13'(STOP_DELAY_CLOCKS - 1);
endpackage

// ---- rtl/interrupt_and_reset_control.sv ----
// Purpose: Vector steering for resets and interrupts, pin controls
// Assumes: Inputs synchronous to ref_clk_i; AXI4-Lite register port
// Notes:   Bus clock equals ref_clk_i; ce_i low freezes all state
//
// What this block does
// - Resets, traps, nonmaskable pin get own vectors
// - Maskable default order from highest vector downward
// - Maskable needs local enable and clear mask
// - Nonmaskable pin level; external pin level selectable
// - Service with no request fetches trap vector
// - Edge mode latches fall, cleared on service
// - Edge select write once; special drops first
// - Edge select one falling edge, zero low level
// - Connect bit always writable, routes pin
// - Stop delay bit; about 4096 clock exit delay
// - Priority select readable; written only when masked
// - Written low byte elevates that source
// - Invalid or above F2 selects external pin
// - Power-up and pin reset share normal vector
// - Reset entry asynchronous, exit needs clock
// - Drive pin low 16, sample 8 later
// - Pin low means external, else internal
// - Priority select resets F2, pin level mode
// - Nonmaskable sources ordered resets, traps, pin
// - Elevation keeps others' order, vectors, masking
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module interrupt_and_reset_control
    import irc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // CPU core side
    input  wire logic        global_mask_i,
    input  wire logic        nmi_mask_i,
    input  wire logic        special_mode_i,
    input  wire logic        svc_start_i,
    input  wire logic        unimpl_trap_i,
    input  wire logic        software_trap_i,
    input  wire logic        stop_exit_i,
    output logic [15:0]      vector_o,
    output logic             vector_valid_o,
    output logic             core_reset_o,
    output logic             stop_resume_o,
    // Peripheral flags and enables, index 1 to 15 of the order
    input  wire logic [15:1] periph_flag_i,
    input  wire logic [15:1] periph_en_i,
    // External pins
    input  wire logic        ext_int_pin_n_i,
    input  wire logic        nonmaskable_pin_n_i,
    input  wire logic        clkmon_fail_i,
    input  wire logic        watchdog_fail_i,
    input  wire logic        reset_pin_i,
    output logic             reset_pin_o,
    output logic             reset_pin_oe_o
);
    typedef enum {st_idle, st_drive, st_wait} rst_state_type;

    // ==========================================================
    // Helpers
    // Lowest index wins unless the elevated source is requesting
    function automatic logic [4:0] pick(input logic [15:0] req,
                                        input logic [7:0]  top);
        logic [4:0] r;
        r = 5'd16;
        for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
            if (req[i]) r = 5'(i);
        end
        for (int i = 0; i < NUM_MASKABLE; i++) begin
            if (MASK_LOW[i] == top && req[i]) r = 5'(i);
        end
        return r;
    endfunction

    function automatic logic [15:0] cause_vec(input logic [1:0] c);
        return (c == CAUSE_CLKMON) ? VEC_CLKMON :
               (c == CAUSE_WDOG)   ? VEC_WDOG   : VEC_RESET;
    endfunction

    // ==========================================================
    // State
    logic [7:0]    pin_ctrl_q;
    logic [7:0]    top_prio_q;
    logic          edge_wrote_q;
    logic          dly_wrote_q;
    logic          edge_latch_q;
    logic          pin_prev_q;
    logic [15:0]   vector_q;
    logic          vector_valid_q;
    rst_state_type rst_state_q;
    logic [4:0]    rst_cnt_q;
    logic          pend_cm_q;
    logic          pend_wd_q;
    logic [1:0]    cause_q;
    logic          stop_busy_q;
    logic [12:0]   stop_cnt_q;
    logic          stop_resume_q;
    logic          aw_have_q;
    logic          w_have_q;
    logic [7:0]    awaddr_q;
    logic [31:0]   wdata_q;
    logic          wstrb0_q;
    logic          bvalid_q;
    logic [1:0]    bresp_q;
    logic          rvalid_q;
    logic [31:0]   rdata_q;
    logic [1:0]    rresp_q;

    // ==========================================================
    // Request decoding
    wire        edge_sel   = pin_ctrl_q[EDGE_SEL_BIT];
    wire        connect    = pin_ctrl_q[CONNECT_BIT];
    wire        delay_en   = pin_ctrl_q[DELAY_BIT];
    wire        pin_fall   = pin_prev_q & ~ext_int_pin_n_i;
    // Level mode for wired-OR sources, edge mode uses the latch
    wire        ext_req    = connect & (edge_sel ? edge_latch_q
                                                 : ~ext_int_pin_n_i);
    wire [15:0] mask_req   = {periph_flag_i & periph_en_i, ext_req};
    wire [15:0] recog      = global_mask_i ? 16'h0000 : mask_req;
    wire [4:0]  win        = pick(recog, top_prio_q);
    wire        nmi_req    = ~nonmaskable_pin_n_i & ~nmi_mask_i;
    wire        in_reset   = (rst_state_q != st_idle);
    wire        svc_take   = svc_start_i & ~in_reset;
    wire        sample_now = (rst_state_q == st_wait) &&
                             (rst_cnt_q == RST_SAMPLE_LAST);
    wire [1:0]  cause_int  = pend_cm_q ? CAUSE_CLKMON :
                             pend_wd_q ? CAUSE_WDOG : CAUSE_NORMAL;
    wire [1:0]  cause_d    = reset_pin_i ? cause_int : CAUSE_NORMAL;

    // Nonmaskable first, then maskable, trap when nothing remains
    wire [15:0] svc_vec    = unimpl_trap_i   ? VEC_UNIMPL :
                             software_trap_i ? VEC_SWTRAP :
                             nmi_req         ? VEC_NMI    :
                             ~win[4] ? {VEC_HIGH, MASK_LOW[win[3:0]]}
                                     : VEC_UNIMPL;
    wire        edge_clr   = svc_take && (svc_vec == {VEC_HIGH, MASK_LOW[0]});

    // ==========================================================
    // Register access decoding
    wire        wr_fire    = aw_have_q & w_have_q & ~bvalid_q;
    wire        wr_ctrl    = wr_fire & wstrb0_q & (awaddr_q == ADDR_PIN_CTRL);
    wire        wr_top     = wr_fire & wstrb0_q & (awaddr_q == ADDR_TOP_PRIO);
    wire        wr_known   = (awaddr_q == ADDR_PIN_CTRL) |
                             (awaddr_q == ADDR_TOP_PRIO) |
                             (awaddr_q == ADDR_STATUS);
    // Special mode drops the first edge select write but keeps all delay writes; normal mode keeps only the first
    wire        edge_upd   = special_mode_i ? edge_wrote_q : ~edge_wrote_q;
    wire        dly_upd    = special_mode_i | ~dly_wrote_q;
    wire [7:0]  ctrl_d     = {edge_upd ? wdata_q[EDGE_SEL_BIT] : edge_sel,
                              wdata_q[CONNECT_BIT],
                              dly_upd ? wdata_q[DELAY_BIT] : delay_en,
                              5'h00};
    wire        rd_fire    = s_axi_arvalid & ~rvalid_q;
    wire [31:0] status_w   = {16'h0000,
                              win[4] ? 8'h00 : MASK_LOW[win[3:0]],
                              4'h0, stop_busy_q, edge_latch_q, cause_q};
    wire [31:0] rd_mux     = (s_axi_araddr == ADDR_PIN_CTRL) ?
                                 {24'h000000, pin_ctrl_q} :
                             (s_axi_araddr == ADDR_TOP_PRIO) ?
                                 {24'h000000, top_prio_q} : status_w;
    wire        rd_known   = (s_axi_araddr == ADDR_PIN_CTRL) |
                             (s_axi_araddr == ADDR_TOP_PRIO) |
                             (s_axi_araddr == ADDR_STATUS);

    assign s_axi_awready  = ~aw_have_q & ~bvalid_q;
    assign s_axi_wready   = ~w_have_q & ~bvalid_q;
    assign s_axi_bvalid   = bvalid_q;
    assign s_axi_bresp    = bresp_q;
    assign s_axi_arready  = ~rvalid_q;
    assign s_axi_rvalid   = rvalid_q;
    assign s_axi_rdata    = rdata_q;
    assign s_axi_rresp    = rresp_q;
    assign vector_o       = vector_q;
    assign vector_valid_o = vector_valid_q;
    assign core_reset_o   = in_reset;
    assign stop_resume_o  = stop_resume_q;
    assign reset_pin_o    = 1'b0;
    assign reset_pin_oe_o = (rst_state_q == st_drive);

    // ==========================================================
    // AXI4-Lite channels
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h00000000;
            wstrb0_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= RESP_OKAY;
        end else if (ce_i) begin
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_known ? rd_mux : 32'h00000000;
                rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_ctrl_q   <= PIN_CTRL_RST;
            top_prio_q   <= TOP_PRIO_RST;
            edge_wrote_q <= 1'b0;
            dly_wrote_q  <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                pin_ctrl_q   <= ctrl_d;
                edge_wrote_q <= 1'b1;
                dly_wrote_q  <= 1'b1;
            end
            // Unmasked writes are dropped but still answered OKAY
            if (wr_top && global_mask_i) begin
                top_prio_q <= wdata_q[7:0];
            end
        end
    end

    // ==========================================================
    // External pin edge latch and vector fetch
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_prev_q     <= 1'b1;
            edge_latch_q   <= 1'b0;
            vector_q       <= VEC_RESET;
            vector_valid_q <= 1'b0;
        end else if (ce_i) begin
            pin_prev_q <= ext_int_pin_n_i;
            // A new edge in the clearing cycle is kept
            if (edge_sel && connect && pin_fall) begin
                edge_latch_q <= 1'b1;
            end else if (edge_clr) begin
                edge_latch_q <= 1'b0;
            end
            vector_valid_q <= sample_now | svc_take;
            if (sample_now) begin
                vector_q <= cause_vec(cause_d);
            end else if (svc_take) begin
                vector_q <= svc_vec;
            end
        end
    end

    // ==========================================================
    // Reset pin drive and classification
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_state_q <= st_drive;
            rst_cnt_q   <= 5'd0;
            pend_cm_q   <= 1'b0;
            pend_wd_q   <= 1'b0;
            cause_q     <= CAUSE_NORMAL;
        end else if (ce_i) begin
            if (clkmon_fail_i) pend_cm_q <= 1'b1;
            if (watchdog_fail_i) pend_wd_q <= 1'b1;
            case (rst_state_q)
                st_idle: begin
                    if (clkmon_fail_i || watchdog_fail_i || !reset_pin_i) begin
                        rst_state_q <= st_drive;
                        rst_cnt_q   <= 5'd0;
                    end
                end
                st_drive: begin
                    rst_cnt_q <= rst_cnt_q + 5'd1;
                    if (rst_cnt_q == RST_DRIVE_LAST) begin
                        rst_state_q <= st_wait;
                        rst_cnt_q   <= 5'd0;
                    end
                end
                st_wait: begin
                    rst_cnt_q <= rst_cnt_q + 5'd1;
                    if (sample_now) begin
                        rst_state_q <= st_idle;
                        cause_q     <= cause_d;
                        pend_cm_q   <= clkmon_fail_i;
                        pend_wd_q   <= watchdog_fail_i;
                    end
                end
                default: rst_state_q <= st_idle;
            endcase
        end
    end

    // ==========================================================
    // Stop exit delay
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_busy_q   <= 1'b0;
            stop_cnt_q    <= 13'h0000;
            stop_resume_q <= 1'b0;
        end else if (ce_i) begin
            stop_resume_q <= 1'b0;
            if (stop_busy_q) begin
                stop_cnt_q <= stop_cnt_q - 13'h0001;
                if (stop_cnt_q == 13'h0000) begin
                    stop_busy_q   <= 1'b0;
                    stop_resume_q <= 1'b1;
                end
            end else if (stop_exit_i) begin
                // Oscillator settle time before the core restarts
                stop_busy_q   <= delay_en;
                stop_cnt_q    <= STOP_DELAY_LAST;
                stop_resume_q <= ~delay_en;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i || !ce_i);

    prio_hold_a: assert property (
        wr_top && !global_mask_i |=> $stable(top_prio_q))
        else $error("priority select changed while unmasked");

    prio_write_a: assert property (
        wr_top && global_mask_i |=> top_prio_q == $past(wdata_q[7:0]))
        else $error("masked priority select write lost");

    pin_drive_a: assert property (
        $rose(reset_pin_oe_o) |->
        reset_pin_oe_o[*8] ##1 reset_pin_oe_o[*8] ##1 !reset_pin_oe_o)
        else $error("reset pin drive length wrong");

    pin_sample_a: assert property (
        $fell(reset_pin_oe_o) |-> !vector_valid_o[*8] ##1 vector_valid_o)
        else $error("reset pin not sampled eight clocks later");

    ext_class_a: assert property (
        sample_now && !reset_pin_i |=> vector_o == VEC_RESET)
        else $error("held pin not classed as external");

    int_class_a: assert property (
        sample_now && reset_pin_i && pend_cm_q |=> vector_o == VEC_CLKMON)
        else $error("internal reset not classed as clock monitor");

    empty_trap_a: assert property (
        svc_take && !unimpl_trap_i && !software_trap_i && !nmi_req &&
        recog == 16'h0000 |=> vector_valid_o && vector_o == VEC_UNIMPL)
        else $error("empty service did not take trap vector");

    nmi_level_a: assert property (
        svc_take && !unimpl_trap_i && !software_trap_i &&
        !nonmaskable_pin_n_i && !nmi_mask_i |=> vector_o == VEC_NMI)
        else $error("nonmaskable pin level not serviced");

    mask_gate_a: assert property (
        svc_take && global_mask_i && !unimpl_trap_i &&
        !software_trap_i && !nmi_req |=> vector_o == VEC_UNIMPL)
        else $error("maskable source passed the global mask");

    edge_clear_a: assert property (
        edge_clr && !pin_fall |=> !edge_latch_q)
        else $error("edge latch not cleared on service");

    edge_once_a: assert property (
        !special_mode_i && edge_wrote_q |=> $stable(edge_sel))
        else $error("edge select changed twice in normal mode");

    stop_fast_a: assert property (
        stop_exit_i && !stop_busy_q && !delay_en |=> stop_resume_o)
        else $error("undelayed stop exit not immediate");
endmodule
`default_nettype wire

// ---- tb/pin_partner.sv ----
// Purpose: Reset pin wire with its pull-up
// Assumes: Open-drain pin, no external reset source on the board
// Notes:   Released pin reads high, never the last driven value
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    // Pin
    input  wire logic oe_i,
    output logic      pin_o
);
    // ====================
    // Pull-up wins whenever the device lets go
    // No board source pulls low, so no short external reset
    assign pin_o = !oe_i;
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for interrupt_and_reset_control
// Assumes: Drivers queue expectations, one monitor compares them
// Notes:   Seed 38; special mode left untouched
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb
    import irc_pkg::*;
();
    // ====================
    // Signals
    logic        clk = '0, rst_n = '0, gm = '1, nm = '0, svc = '0;
    logic        unimp = '0, swt = '0, irq_n = '1, nmi_n = '1;
    logic        cmf = '0, wdf = '0, awv = '0, wv = '0, bry = '0, stp = '0;
    logic        arv = '0, rry = '0, awr, wr, bv, arr, rv, oe, vv, cr, pin;
    logic [7:0]  awa = '0, wd = '0, tp;
    logic [15:1] flg = '0, en = '1, rf, re;
    logic [1:0]  br, rr;
    logic [31:0] rdat;
    logic [15:0] vec, ev, e;
    logic [33:0] ea, qa[$];
    logic [15:0] qv[$];
    logic        m, sr;
    int          n_fail = 0, total_checks = 0, i, j, k;
    localparam logic [33:0] WR_OKAY = {RESP_OKAY, 32'h0};
    interrupt_and_reset_control u_dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'h1),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata({24'h0, wd}), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(awa), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .global_mask_i(gm),
        .nmi_mask_i(nm), .special_mode_i(1'h0), .svc_start_i(svc),
        .unimpl_trap_i(unimp), .software_trap_i(swt), .stop_exit_i(stp),
        .vector_o(vec), .vector_valid_o(vv), .core_reset_o(cr),
        .stop_resume_o(sr), .periph_flag_i(flg), .periph_en_i(en),
        .ext_int_pin_n_i(irq_n), .nonmaskable_pin_n_i(nmi_n),
        .clkmon_fail_i(cmf), .watchdog_fail_i(wdf), .reset_pin_i(pin),
        .reset_pin_o(), .reset_pin_oe_o(oe));
    pin_partner u_pin (.oe_i(oe), .pin_o(pin));
    initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    // ====================
    // Monitor: oldest note against each result
    always @(posedge clk) begin
        if (vv) begin
            ev = qv.size() ? qv.pop_front() : 'x;
            `CHK(vec, ev)
        end
        if (bv && bry || rv && rry) begin
            ea = qa.size() ? qa.pop_front() : 'x;
            `CHK(bv ? {br, 32'h0} : {rr, rdat}, ea)
        end
    end
    task automatic finish_test;
        if (qv.size() || qa.size()) n_fail++;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Readies sampled at the falling edge, acted on at the rising one
    task automatic axi(input logic w, input logic [7:0] a, d,
                       input logic [33:0] x);
        logic ah, wh, dn;
        int   t;
        @(posedge clk);
        qa.push_back(x);
        awa <= a; wd <= d; awv <= w; wv <= w; bry <= w; arv <= !w; rry <= !w;
        for (t = 0; t < 40; t++) begin
            @(negedge clk);
            ah = awv && awr || arv && arr;
            wh = wv && wr;
            dn = bv && bry || rv && rry;
            @(posedge clk);
            if (ah) begin awv <= '0; arv <= '0; end
            if (wh) wv <= '0;
            if (dn) begin bry <= '0; rry <= '0; break; end
        end
        if (t == 40) begin n_fail++; finish_test(); end
    endtask
    task automatic serve(input logic [15:0] x);
        @(posedge clk);
        qv.push_back(x);
        svc <= '1;
        @(posedge clk);
        svc <= '0;
        repeat (2) @(posedge clk);
    endtask
    task automatic fall;
        @(posedge clk) irq_n <= '0;
        @(posedge clk) irq_n <= '1;
    endtask
    task automatic rst_seq(input logic [15:0] x);
        int t, n;
        qv.push_back(x);
        n = 0;
        for (t = 0; t < 300; t++) begin
            @(negedge clk);
            n += oe;
            if (!cr && n > 0) break;
        end
        if (t == 300) begin n_fail++; finish_test(); end
        `CHK(n, RST_DRIVE_CLOCKS)
        repeat (3) @(posedge clk);
    endtask
    // ====================
    // Main sequence
    initial begin
        k = $urandom(38);
        repeat (12) @(posedge clk);
        rst_n <= '1;
        rst_seq(VEC_RESET);
        // Delay bit is set out of reset
        stp <= '1;
        @(posedge clk) stp <= '0;
        for (i = 0; i < 5000; i++) begin
            @(negedge clk);
            if (sr) break;
        end
        `CHK(i, STOP_DELAY_CLOCKS)
        axi(0, ADDR_PIN_CTRL, 0, {RESP_OKAY, 24'h0, PIN_CTRL_RST});
        axi(0, ADDR_TOP_PRIO, 0, {RESP_OKAY, 24'h0, TOP_PRIO_RST});
        axi(1, 8'h0C, 8'h5A, {RESP_SLVERR, 32'h0});
        axi(0, 8'h0C, 0, {RESP_SLVERR, 32'h0});
        gm <= '0;
        axi(1, ADDR_TOP_PRIO, 8'hF0, WR_OKAY);
        axi(0, ADDR_TOP_PRIO, 0, {RESP_OKAY, 24'h0, 8'hF2});
        flg <= '1;
        for (k = 0; k < 5; k++) begin
            unimp <= k < 1; swt <= k < 2; nmi_n <= k > 3; nm <= k == 3;
            e = k < 3 ? (k < 1 ? VEC_UNIMPL : k < 2 ? VEC_SWTRAP : VEC_NMI)
                      : {VEC_HIGH, MASK_LOW[1]};
            serve(e);
        end
        for (k = 0; k < 30; k++) begin
            gm <= '1;
            j = 1 + $urandom % 17;
            tp = j > 15 ? (j > 16 ? 8'hD4 : 8'hF4) : MASK_LOW[j];
            axi(1, ADDR_TOP_PRIO, tp, WR_OKAY);
            rf = 15'($urandom); re = 15'($urandom); m = $urandom % 4 == 0;
            flg <= rf; en <= re; gm <= m;
            e = VEC_UNIMPL;
            for (i = 15; i >= 1; i--)
                if (rf[i] && re[i]) e = {VEC_HIGH, MASK_LOW[i]};
            if (j < 16 && rf[j] && re[j]) e = {VEC_HIGH, tp};
            if (m) e = VEC_UNIMPL;
            serve(e);
        end
        gm <= '1;
        flg <= '0;
        @(posedge clk) gm <= '0;
        irq_n <= '0;
        serve({VEC_HIGH, 8'hF2});
        serve({VEC_HIGH, 8'hF2});
        irq_n <= '1; gm <= '1;
        axi(1, ADDR_PIN_CTRL, 8'hC0, WR_OKAY);
        axi(1, ADDR_PIN_CTRL, 8'h00, WR_OKAY);
        axi(0, ADDR_PIN_CTRL, 0, {RESP_OKAY, 24'h0, 8'h80});
        stp <= '1;
        @(posedge clk) stp <= '0;
        @(negedge clk) `CHK(sr, 1'b1)
        fall(); gm <= '0;
        serve(VEC_UNIMPL);
        gm <= '1;
        axi(1, ADDR_PIN_CTRL, 8'h40, WR_OKAY);
        fall(); gm <= '0;
        serve({VEC_HIGH, 8'hF2});
        serve(VEC_UNIMPL);
        for (k = 0; k < 2; k++) begin
            @(posedge clk) begin cmf <= k == 0; wdf <= k == 1; end
            @(posedge clk) begin cmf <= '0; wdf <= '0; end
            rst_seq(k == 0 ? VEC_CLKMON : VEC_WDOG);
        end
        repeat (4) @(posedge clk);
        finish_test();
    end
endmodule
`default_nettype wire
